// [design/smcg_pkg.sv]
// Package for the sleep mode clock gating block: modes, states, domain enables, reset values
package smcg_pkg;
	// Sleep mode selection codes
	typedef enum logic [2:0] {
		SMCG_MODE_IDLE = 3'h0,
		SMCG_MODE_ADC_NR = 3'h1,
		SMCG_MODE_PWR_DOWN = 3'h2,
		SMCG_MODE_PWR_SAVE = 3'h3,
		SMCG_MODE_STANDBY = 3'h6,
		SMCG_MODE_EXT_STANDBY = 3'h7
	} smcg_mode_e;

	// Controller states
	typedef enum logic [1:0] {
		SMCG_ST_ACTIVE = 2'h0,
		SMCG_ST_SLEEP = 2'h1
	} smcg_state_e;

	// One enable per clock domain
	typedef struct packed {
		logic cpu;
		logic sram;
		logic timer;
		logic spi;
		logic irq;
		logic adc;
		logic async_tmr;
		logic main_osc;
	} smcg_dom_s;

	localparam smcg_dom_s SMCG_DOM_ALL_ON = 8'hFF;
	localparam smcg_mode_e SMCG_MODE_RST = SMCG_MODE_IDLE;
	localparam logic SMCG_WAKE_RST = 1'b0;
endpackage

// [design/smcg_sleep_ctrl.sv]
// Sleep mode controller gating the core and peripheral clock domains
`timescale 1ns/1ps

// Contract
// - Six distinct sleep modes, any selectable by software.
// - Idle: CPU stopped; SRAM, timers, SPI, interrupts keep clocks.
// - Power-down: oscillator and all functions off until interrupt or reset.
// - Power-save: only asynchronous timer runs, keeping a time base.
// - ADC noise reduction: only ADC and asynchronous timer run; the code also keeps the main oscillator running.
// - Standby: main oscillator keeps running, everything else sleeps.
// - Extended standby: main oscillator and asynchronous timer run.
module smcg_sleep_ctrl (
	input wire logic clk_i, // System clock, 100 MHz
	input wire logic rst_n_i, // Async reset, active low
	input wire logic sleep_req_i, // CPU sleep request pulse
	input wire logic [2:0] sleep_mode_i, // Requested sleep mode code
	input wire logic wake_irq_i, // Wake interrupt, synchronous level
	output smcg_pkg::smcg_dom_s dom_en_o, // Domain clock enables
	output logic sleeping_o, // High while asleep
	output logic mode_err_o // Pulse on unsupported mode code
);

	smcg_pkg::smcg_state_e state_reg, state_next;
	smcg_pkg::smcg_mode_e mode_reg, mode_next;
	smcg_pkg::smcg_dom_s dom_reg, dom_next;
	logic err_reg, err_next;
	logic sleep_reg, sleep_next;

	// Mode code legality check
	function automatic logic mode_ok(input logic [2:0] m);
		case (m)
			3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7: mode_ok = 1'b1;
			default: mode_ok = 1'b0;
		endcase
	endfunction

	// Domain enables for a sleep mode
	function automatic smcg_pkg::smcg_dom_s mode_doms(input smcg_pkg::smcg_mode_e m);
		smcg_pkg::smcg_dom_s d;
		d = '0;
		unique case (m)
			smcg_pkg::SMCG_MODE_IDLE: begin
				d = smcg_pkg::SMCG_DOM_ALL_ON;
				d.cpu = 1'b0;
			end
			smcg_pkg::SMCG_MODE_ADC_NR: begin
				d.adc = 1'b1;
				d.async_tmr = 1'b1;
				d.main_osc = 1'b1;
			end
			smcg_pkg::SMCG_MODE_PWR_DOWN: d = '0;
			smcg_pkg::SMCG_MODE_PWR_SAVE: d.async_tmr = 1'b1;
			smcg_pkg::SMCG_MODE_STANDBY: d.main_osc = 1'b1;
			smcg_pkg::SMCG_MODE_EXT_STANDBY: begin
				d.main_osc = 1'b1;
				d.async_tmr = 1'b1;
			end
		endcase
		mode_doms = d;
	endfunction

	// Next-state logic: sleep on request, wake on interrupt
	always_comb begin
		state_next = state_reg;
		mode_next = mode_reg;
		dom_next = dom_reg;
		err_next = 1'b0;
		unique case (state_reg)
			smcg_pkg::SMCG_ST_ACTIVE: begin
				if (sleep_req_i && !wake_irq_i) begin
					if (mode_ok(sleep_mode_i)) begin
						mode_next = smcg_pkg::smcg_mode_e'(sleep_mode_i);
						dom_next = mode_doms(smcg_pkg::smcg_mode_e'(sleep_mode_i));
						state_next = smcg_pkg::SMCG_ST_SLEEP;
					end else begin
						err_next = 1'b1;
					end
				end
			end
			smcg_pkg::SMCG_ST_SLEEP: begin
				if (wake_irq_i) begin
					dom_next = smcg_pkg::SMCG_DOM_ALL_ON;
					state_next = smcg_pkg::SMCG_ST_ACTIVE;
				end
			end
			default: begin
				state_next = smcg_pkg::SMCG_ST_ACTIVE;
				dom_next = smcg_pkg::SMCG_DOM_ALL_ON;
			end
		endcase
		sleep_next = (state_next == smcg_pkg::SMCG_ST_SLEEP); // Registered copy of the sleep state
	end

	// State registers; reset gives full activity
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= smcg_pkg::SMCG_ST_ACTIVE;
			mode_reg <= smcg_pkg::SMCG_MODE_RST;
			dom_reg <= smcg_pkg::SMCG_DOM_ALL_ON;
			err_reg <= smcg_pkg::SMCG_WAKE_RST;
			sleep_reg <= smcg_pkg::SMCG_WAKE_RST;
		end else begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			dom_reg <= dom_next;
			err_reg <= err_next;
			sleep_reg <= sleep_next;
		end
	end

	// Outputs straight from flip-flops
	assign dom_en_o = dom_reg;
	assign sleeping_o = sleep_reg;
	assign mode_err_o = err_reg;

	// Idle keeps every domain but the CPU
	property p_idle;
		@(posedge clk_i) disable iff (!rst_n_i)
		(state_reg == smcg_pkg::SMCG_ST_ACTIVE && sleep_req_i && !wake_irq_i && sleep_mode_i == 3'h0)
		|=> (dom_en_o == 8'h7F);
	endproperty
	a_idle: assert property (p_idle) else $error("idle enables wrong");

	property p_pdown;
		@(posedge clk_i) disable iff (!rst_n_i)
		(sleeping_o && mode_reg == smcg_pkg::SMCG_MODE_PWR_DOWN) |-> (dom_en_o == 8'h00);
	endproperty
	a_pdown: assert property (p_pdown) else $error("power-down domains active");

	property p_psave;
		@(posedge clk_i) disable iff (!rst_n_i)
		(sleeping_o && mode_reg == smcg_pkg::SMCG_MODE_PWR_SAVE) |-> (dom_en_o == 8'h02);
	endproperty
	a_psave: assert property (p_psave) else $error("power-save enables wrong");

	property p_adcnr;
		@(posedge clk_i) disable iff (!rst_n_i)
		(sleeping_o && mode_reg == smcg_pkg::SMCG_MODE_ADC_NR) |-> (dom_en_o == 8'h07);
	endproperty
	a_adcnr: assert property (p_adcnr) else $error("adc noise mode enables wrong");

	property p_stby;
		@(posedge clk_i) disable iff (!rst_n_i)
		(sleeping_o && mode_reg == smcg_pkg::SMCG_MODE_STANDBY) |-> (dom_en_o == 8'h01);
	endproperty
	a_stby: assert property (p_stby) else $error("standby enables wrong");

	property p_xstby;
		@(posedge clk_i) disable iff (!rst_n_i)
		(sleeping_o && mode_reg == smcg_pkg::SMCG_MODE_EXT_STANDBY) |-> (dom_en_o == 8'h03);
	endproperty
	a_xstby: assert property (p_xstby) else $error("ext standby enables wrong");

	property p_wake;
		@(posedge clk_i) disable iff (!rst_n_i)
		(sleeping_o && wake_irq_i) |=> (!sleeping_o && dom_en_o == 8'hFF);
	endproperty
	a_wake: assert property (p_wake) else $error("wake did not restore domains");

	property p_noreq;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!sleeping_o && !sleep_req_i) |=> !sleeping_o;
	endproperty
	a_noreq: assert property (p_noreq) else $error("sleep without request");

	property p_sel;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!sleeping_o && sleep_req_i && !wake_irq_i && sleep_mode_i == 3'h3)
		|=> (sleeping_o && mode_reg == smcg_pkg::SMCG_MODE_PWR_SAVE);
	endproperty
	a_sel: assert property (p_sel) else $error("mode not selected");

	property p_err;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!sleeping_o && sleep_req_i && !wake_irq_i && sleep_mode_i == 3'h4) |=> (mode_err_o && !sleeping_o);
	endproperty
	a_err: assert property (p_err) else $error("illegal mode not refused");

	// Second unsupported code is refused too
	property p_err5;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!sleeping_o && sleep_req_i && !wake_irq_i && sleep_mode_i == 3'h5) |=> (mode_err_o && !sleeping_o);
	endproperty
	a_err5: assert property (p_err5) else $error("second illegal mode not refused");

	// Any supported code puts the block to sleep without error
	property p_legal;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!sleeping_o && sleep_req_i && !wake_irq_i && sleep_mode_i != 3'h4 && sleep_mode_i != 3'h5)
		|=> (sleeping_o && !mode_err_o);
	endproperty
	a_legal: assert property (p_legal) else $error("legal mode not entered");

	// No error pulse while asleep
	property p_noerr;
		@(posedge clk_i) disable iff (!rst_n_i)
		sleeping_o |-> !mode_err_o;
	endproperty
	a_noerr: assert property (p_noerr) else $error("error pulse while asleep");

	// Every sleep mode stops the CPU clock
	property p_cpu_off;
		@(posedge clk_i) disable iff (!rst_n_i)
		sleeping_o |-> !dom_en_o.cpu;
	endproperty
	a_cpu_off: assert property (p_cpu_off) else $error("cpu clock runs while asleep");

	// Sleep and its enables hold until an interrupt
	property p_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		(sleeping_o && !wake_irq_i) |=> (sleeping_o && $stable(dom_en_o));
	endproperty
	a_hold: assert property (p_hold) else $error("sleep left without interrupt");

	// Active state keeps every domain clocked
	property p_act_all;
		@(posedge clk_i) disable iff (!rst_n_i)
		!sleeping_o |-> (dom_en_o == 8'hFF);
	endproperty
	a_act_all: assert property (p_act_all) else $error("domain stopped while active");

	// Wake beats a simultaneous request, silently
	property p_mask;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!sleeping_o && sleep_req_i && wake_irq_i) |=> (!sleeping_o && !mode_err_o);
	endproperty
	a_mask: assert property (p_mask) else $error("request with wake not ignored");

endmodule // smcg_sleep_ctrl

// [bench/smcg_dom_model.sv]
// Model of the CPU clock domain fed by the gated enable
`timescale 1ns/1ps
module smcg_dom_model (
	input wire logic clk_i, // System clock
	input wire logic rst_n_i, // Async reset, active low
	input smcg_pkg::smcg_dom_s dom_en_i, // Domain clock enables
	output logic [7:0] cpu_ticks_o // CPU clocks received
);
	// CPU advances only on enabled clocks
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cpu_ticks_o <= 8'h00;
		end else if (dom_en_i.cpu) begin
			cpu_ticks_o <= cpu_ticks_o + 8'h01;
		end
	end
endmodule // smcg_dom_model

// [bench/tb_smcg_sleep_ctrl.sv]
// Testbench for the sleep mode clock gating block
`timescale 1ns/1ps
module tb_smcg_sleep_ctrl;
	logic clk_i = 0, rst_n_i = 0, sleep_req_i = 0, wake_irq_i = 0;
	logic [2:0] sleep_mode_i = 3'h0;
	smcg_pkg::smcg_dom_s dom_en_o;
	logic sleeping_o, mode_err_o;
	logic [7:0] cpu_ticks, t;
	int error_cnt = 0, num_checks = 0, seed = 32'hD991;
	always #5 clk_i = ~clk_i;
	smcg_sleep_ctrl smcg_sleep_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .sleep_req_i(sleep_req_i),
		.sleep_mode_i(sleep_mode_i), .wake_irq_i(wake_irq_i), .dom_en_o(dom_en_o), .sleeping_o(sleeping_o),
		.mode_err_o(mode_err_o));
	smcg_dom_model smcg_dom_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .dom_en_i(dom_en_o),
		.cpu_ticks_o(cpu_ticks));
	// Compare and count
	task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", name, exp, got);
		end
	endtask
	// Expected enables, sleep flag and error flag per code
	function automatic logic [9:0] model(input int m);
		case (m)
			0: return {8'h7F, 2'b10};
			1: return {8'h07, 2'b10};
			2: return {8'h00, 2'b10};
			3: return {8'h02, 2'b10};
			6: return {8'h01, 2'b10};
			7: return {8'h03, 2'b10};
			default: return {8'hFF, 2'b01};
		endcase
	endfunction
	// Request, stray request while asleep, then wake
	task cycle(input int m, input logic wk);
		@(posedge clk_i);
		sleep_req_i <= 1'b1;
		sleep_mode_i <= m[2:0];
		wake_irq_i <= wk;
		@(posedge clk_i);
		sleep_req_i <= 1'b0;
		wake_irq_i <= 1'b0;
		#1 chk("answer", wk ? 10'h3FC : model(m), {dom_en_o, sleeping_o, mode_err_o});
		t = cpu_ticks;
		if (!wk && model(m) !== 10'h3FD) begin
			@(posedge clk_i);
			sleep_req_i <= 1'b1;
			sleep_mode_i <= 3'h2;
			@(posedge clk_i);
			sleep_req_i <= 1'b0;
			#1 chk("hold", model(m), {dom_en_o, sleeping_o, mode_err_o});
			chk("cpu_ticks", {2'b00, t}, {2'b00, cpu_ticks});
			@(posedge clk_i);
			wake_irq_i <= 1'b1;
			@(posedge clk_i);
			wake_irq_i <= 1'b0;
			#1 chk("wake", 10'h3FC, {dom_en_o, sleeping_o, mode_err_o});
		end
	endtask
	// Hardware reset in power-down restores every domain
	task reset_wake();
		@(posedge clk_i);
		sleep_req_i <= 1'b1;
		sleep_mode_i <= 3'h2;
		@(posedge clk_i);
		sleep_req_i <= 1'b0;
		#1 chk("asleep", 10'h002, {dom_en_o, sleeping_o, mode_err_o});
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		#1 chk("reset_wake", 10'h3FC, {dom_en_o, sleeping_o, mode_err_o});
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		#1 chk("reset_rel", 10'h3FC, {dom_en_o, sleeping_o, mode_err_o});
	endtask
	// Print verdict and stop
	task close_out();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1 chk("reset", 10'h3FC, {dom_en_o, sleeping_o, mode_err_o});
		for (int m = 0; m < 8; m++) cycle(m, 1'b0);
		cycle(3, 1'b1);
		reset_wake();
		repeat (6) cycle($random(seed) & 7, 1'b0);
		close_out();
	end
	// Hang guard
	initial begin
		#20000;
		error_cnt++;
		close_out();
	end
endmodule // tb_smcg_sleep_ctrl
